// ===== spi_buf_monitor.sv
// checker of bus, register and interrupt behaviour at the top ports
`timescale 1ns/1ps
module spi_buf_monitor
  import spi_buf_pkg::*;
(
  // watched ports
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic irq_out
);
  logic take;
  logic wr;
  logic [7:0] con1_reg;
  logic [7:0] stat_reg;
  logic [7:0] mask_reg;
  assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr = take && wb_we_in && wb_sel_in[0];
  // shadow copies of what software wrote
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      con1_reg <= CON1_RST;
      stat_reg <= STAT_RST;
      mask_reg <= 8'h00;
    end else if (wr) begin
      if (wb_adr_in == CON1_OFS) con1_reg <= wb_dat_in[7:0];
      if (wb_adr_in == STAT_OFS) stat_reg <= wb_dat_in[7:0];
      if (wb_adr_in == IRQ_MASK_OFS) mask_reg <= wb_dat_in[7:0];
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  a_ack_follows_take: assert property (take |=> wb_ack_out)
    else $error("request without ack");
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property
    (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_idle_data_zero: assert property
    (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_upper_bits_zero: assert property
    (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property
    (take && !wb_we_in && wb_adr_in == 8'h20 |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  a_con1_readback: assert property
    (take && !wb_we_in && wb_adr_in == CON1_OFS
    |=> wb_dat_out[7:0] == con1_reg)
    else $error("control one readback wrong");
  a_stat_top_rw: assert property
    (take && !wb_we_in && wb_adr_in == STAT_OFS
    |=> wb_dat_out[7:6] == stat_reg[7:6])
    else $error("status top bits readback wrong");
  a_irq_masked_low: assert property
    ((mask_reg == 8'h00) [*3] |-> !irq_out)
    else $error("interrupt while masked");
  cover property (wr && wb_adr_in == BUF_OFS);
  cover property ($rose(irq_out));
  cover property (take && !wb_we_in && wb_adr_in == BUF_OFS);
endmodule // spi_buf_monitor

bind spi_buffer_register_path spi_buf_monitor mon (.mclk_in, .rstn_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
  .wb_dat_out, .wb_ack_out, .irq_out);

// ===== spi_buf_pkg.sv
// package: register map, field positions and types of the serial port
package spi_buf_pkg;
  localparam logic [7:0] STAT_OFS = 8'h00;
  localparam logic [7:0] CON1_OFS = 8'h04;
  localparam logic [7:0] CON3_OFS = 8'h08;
  localparam logic [7:0] BUF_OFS = 8'h0C;
  localparam logic [7:0] BAUD_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] CON1_RST = 8'h00;
  localparam logic [7:0] CON3_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] STAT_WR_MASK = 8'hC0;
  localparam logic [7:0] STAT_RO_MASK = 8'h3F;
  localparam int CON1_EN_BIT = 5;
  localparam int CON1_MASTER_BIT = 0;
  localparam int STAT_BF_BIT = 0;
  localparam int IRQ_BYTE_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef enum logic {idle_st, shift_st} shift_state_type;
endpackage

// ===== spi_buffer_register_path.sv
// serial port register and data-buffer path with wishbone slave
`timescale 1ns/1ps

module spi_buffer_register_path
  import spi_buf_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // serial pins
  input wire logic sck_in,
  input wire logic sdi_in,
  output logic sck_out,
  output logic sdo_out,
  // interrupt
  output logic irq_out
);

  logic rst_meta_reg;
  logic rstn_reg;
  logic sck_meta_reg;
  logic sck_sync_reg;
  logic sck_prev_reg;
  logic sdi_meta_reg;
  logic sdi_sync_reg;
  logic [7:0] stat_reg;
  logic [7:0] con1_reg;
  logic [7:0] con3_reg;
  logic [7:0] buf_reg;
  logic [7:0] baud_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] brg_cnt_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic byte_done_reg;
  logic sck_gen_reg;
  logic tx_bit_reg;
  shift_state_type state_reg;
  wb_req_type req;
  logic wr_stb;
  logic rd_stb;
  logic buf_wr;
  logic enabled;
  logic is_master;
  logic sck_rise;
  logic sck_fall;
  logic brg_tick;
  logic byte_done;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in,
                 adr: wb_adr_in, sel: wb_sel_in, dat: wb_dat_in};
  assign wr_stb = req.cyc && req.stb && req.we && !wb_ack_out && req.sel[0];
  assign rd_stb = req.cyc && req.stb && !wb_ack_out;
  assign buf_wr = wr_stb && hit(req.adr, BUF_OFS);
  assign enabled = con1_reg[CON1_EN_BIT];
  assign is_master = con1_reg[CON1_MASTER_BIT];

  // reset release
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rstn_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rstn_reg <= rst_meta_reg;
    end
  end

  // serial clock pin synchroniser; history starts at the idle level
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      sck_meta_reg <= 1'b0;
      sck_sync_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_meta_reg <= sck_in;
      sck_sync_reg <= sck_meta_reg;
      sck_prev_reg <= sck_sync_reg;
    end
  end

  // serial data pin synchroniser
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
    end else begin
      sdi_meta_reg <= sdi_in;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  // baud generator for master serial clock
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      brg_cnt_reg <= BAUD_RST;
      sck_gen_reg <= 1'b0;
    end else if (state_reg != shift_st || !is_master) begin
      brg_cnt_reg <= baud_reg;
      sck_gen_reg <= 1'b0;
    end else if (brg_cnt_reg == 8'h00) begin
      brg_cnt_reg <= baud_reg;
      sck_gen_reg <= !sck_gen_reg;
    end else begin
      brg_cnt_reg <= brg_cnt_reg - 8'h01;
    end
  end

  assign brg_tick = (brg_cnt_reg == 8'h00) && state_reg == shift_st;
  assign sck_rise = is_master ? (brg_tick && !sck_gen_reg)
                              : (sck_sync_reg && !sck_prev_reg);
  assign sck_fall = is_master ? (brg_tick && sck_gen_reg)
                              : (!sck_sync_reg && sck_prev_reg);
  assign byte_done = sck_rise && bit_cnt_reg == BIT_CNT_LAST
                     && state_reg == shift_st && enabled;

  // shift engine
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      state_reg <= idle_st;
      shift_reg <= BUF_RST;
      bit_cnt_reg <= BIT_CNT_RST;
      byte_done_reg <= 1'b0;
    end else begin
      byte_done_reg <= byte_done;
      case (state_reg)
        idle_st: begin
          bit_cnt_reg <= BIT_CNT_RST;
          if (buf_wr) begin
            shift_reg <= req.dat[7:0];
            if (enabled) begin
              state_reg <= shift_st;
            end
          end
        end
        shift_st: begin
          if (!enabled) begin
            state_reg <= idle_st;
          end else if (sck_rise) begin
            shift_reg <= {shift_reg[6:0], sdi_sync_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == BIT_CNT_LAST) begin
              state_reg <= idle_st;
            end
          end
        end
        default: state_reg <= idle_st;
      endcase
    end
  end

  // data buffer
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      buf_reg <= BUF_RST;
    end else if (byte_done) begin
      buf_reg <= {shift_reg[6:0], sdi_sync_reg};
    end else if (buf_wr) begin
      buf_reg <= req.dat[7:0];
    end
  end

  // control one
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      con1_reg <= CON1_RST;
    end else if (wr_stb && hit(req.adr, CON1_OFS)) begin
      con1_reg <= req.dat[7:0];
    end
  end

  // control three
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      con3_reg <= CON3_RST;
    end else if (wr_stb && hit(req.adr, CON3_OFS)) begin
      con3_reg <= req.dat[7:0];
    end
  end

  // baud value
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      baud_reg <= BAUD_RST;
    end else if (wr_stb && hit(req.adr, BAUD_OFS)) begin
      baud_reg <= req.dat[7:0];
    end
  end

  // status: top two bits writable, low six from hardware
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      stat_reg <= STAT_RST;
    end else begin
      if (wr_stb && hit(req.adr, STAT_OFS)) begin
        stat_reg[7:6] <= req.dat[7:6];
      end
      stat_reg[5:0] <= {5'h00, byte_done_reg | (stat_reg[STAT_BF_BIT]
        && !(rd_stb && !req.we && hit(req.adr, BUF_OFS)))};
    end
  end

  // interrupt mask
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      irq_mask_reg <= 2'h0;
    end else if (wr_stb && hit(req.adr, IRQ_MASK_OFS)) begin
      irq_mask_reg <= req.dat[1:0];
    end
  end

  // interrupt status: a new event wins over a write-one clear
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      irq_stat_reg <= 2'h0;
    end else if (wr_stb && hit(req.adr, IRQ_STAT_OFS)) begin
      irq_stat_reg <= (irq_stat_reg & ~req.dat[1:0])
        | {byte_done && stat_reg[STAT_BF_BIT], byte_done};
    end else begin
      irq_stat_reg <= irq_stat_reg
        | {byte_done && stat_reg[STAT_BF_BIT], byte_done};
    end
  end

  // wishbone answer
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= rd_stb;
      wb_dat_out <= 32'h0000_0000;
      if (rd_stb && !req.we) begin
        if (hit(req.adr, STAT_OFS)) begin
          wb_dat_out <= {24'h000000, stat_reg};
        end else if (hit(req.adr, CON1_OFS)) begin
          wb_dat_out <= {24'h000000, con1_reg};
        end else if (hit(req.adr, CON3_OFS)) begin
          wb_dat_out <= {24'h000000, con3_reg};
        end else if (hit(req.adr, BUF_OFS)) begin
          wb_dat_out <= {24'h000000, buf_reg};
        end else if (hit(req.adr, BAUD_OFS)) begin
          wb_dat_out <= {24'h000000, baud_reg};
        end else if (hit(req.adr, IRQ_STAT_OFS)) begin
          wb_dat_out <= {30'h0, irq_stat_reg};
        end else if (hit(req.adr, IRQ_MASK_OFS)) begin
          wb_dat_out <= {30'h0, irq_mask_reg};
        end
      end
    end
  end

  // outgoing bit moves on the falling edge, settled at every rise
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      tx_bit_reg <= 1'b0;
    end else if (state_reg == idle_st && buf_wr) begin
      tx_bit_reg <= req.dat[7];
    end else if (state_reg == shift_st && sck_fall) begin
      tx_bit_reg <= shift_reg[7];
    end
  end

  // generated serial clock
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      sck_out <= 1'b0;
    end else begin
      sck_out <= sck_gen_reg;
    end
  end

  // serial data out
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      sdo_out <= 1'b0;
    end else begin
      sdo_out <= tx_bit_reg;
    end
  end

  // interrupt line
  always_ff @(posedge mclk_in or negedge rstn_reg) begin
    if (!rstn_reg) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // spi_buffer_register_path

// ===== spi_far_model.sv
// far-side serial slave that shifts one byte out and one in
`timescale 1ns/1ps
module spi_far_model (
  // serial side
  input wire logic sck_in,
  input wire logic sdo_in,
  output logic sdi_out,
  // bench side
  input wire logic [7:0] tx_in,
  input wire logic load_in,
  output logic [7:0] rx_out
);
  logic [7:0] sh_reg;
  // after the byte the line shows inverted garbage, not the last bit
  always @(negedge sck_in or posedge load_in) begin
    if (load_in) sh_reg <= tx_in;
    else sh_reg <= {sh_reg[6:0], ~sh_reg[0]};
  end
  always @(posedge sck_in) rx_out <= {rx_out[6:0], sdo_in};
  assign sdi_out = sh_reg[7];
endmodule // spi_far_model

// ===== testbench.sv
// self-checking bench for the serial port register path
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module testbench;
  import spi_buf_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic load = 1'b0;
  logic sck_pin = 1'b0;
  logic link_sck;
  logic [3:0] sel = 4'hF;
  logic [7:0] q;
  logic [7:0] rx;
  logic [31:0] rdat;
  logic ack, sck, sdo, sdi, irq;
  assign link_sck = sck | sck_pin;
  wb_req_type req = '0;
  int fails = 0;
  int checks = 0;
  always #20 mclk_in = ~mclk_in;
  spi_buffer_register_path uut (.mclk_in, .rstn_in, .wb_cyc_in(req.cyc),
    .wb_stb_in(req.stb), .wb_we_in(req.we), .wb_adr_in(req.adr),
    .wb_sel_in(req.sel), .wb_dat_in(req.dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .sck_in(sck_pin), .sdi_in(sdi), .sck_out(sck),
    .sdo_out(sdo), .irq_out(irq));
  spi_far_model far (.sck_in(link_sck), .sdo_in(sdo), .sdi_out(sdi),
    .tx_in(8'hA5), .load_in(load), .rx_out(rx));
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    req <= '{1'b1, 1'b1, w, a, sel, {24'h0, d}};
    do begin @(posedge mclk_in); end while (ack !== 1'b1);
    q = rdat[7:0];
    req <= '0;
  endtask
  task settle;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  task t_reset;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00);
      `CHK(q, 8'h00)
    end
    bus(1'b0, 8'h20, 8'h00);
    `CHK(q, 8'h00)
    $display("test reset done");
  endtask
  task t_con1;
    bus(1'b1, CON1_OFS, 8'hDE);
    bus(1'b0, CON1_OFS, 8'h00);
    `CHK(q, 8'hDE)
    sel <= 4'hE;
    bus(1'b1, CON1_OFS, 8'h11);
    sel <= 4'hF;
    bus(1'b0, CON1_OFS, 8'h00);
    `CHK(q, 8'hDE)
    bus(1'b1, CON1_OFS, 8'h00);
    bus(1'b1, CON3_OFS, 8'h5C);
    bus(1'b0, CON3_OFS, 8'h00);
    `CHK(q, 8'h5C)
    $display("test control done");
  endtask
  task t_stat;
    bus(1'b1, STAT_OFS, 8'hFF);
    bus(1'b0, STAT_OFS, 8'h00);
    `CHK(q, 8'hC0)
    bus(1'b1, STAT_OFS, 8'h00);
    bus(1'b0, STAT_OFS, 8'h00);
    `CHK(q, 8'h00)
    $display("test status done");
  endtask
  task t_xfer;
    int n;
    n = 0;
    load <= 1'b1;
    bus(1'b1, IRQ_MASK_OFS, 8'h01);
    load <= 1'b0;
    bus(1'b1, BAUD_OFS, 8'h03);
    bus(1'b0, BAUD_OFS, 8'h00);
    `CHK(q, 8'h03)
    bus(1'b1, CON1_OFS, 8'h21);
    bus(1'b1, BUF_OFS, 8'h3C);
    while (irq !== 1'b1 && n < 500) begin @(posedge mclk_in); n++; end
    `CHK(n >= 56 && n < 500, 1'b1)
    `CHK(rx, 8'h3C)
    bus(1'b0, STAT_OFS, 8'h00);
    `CHK(q[STAT_BF_BIT], 1'b1)
    `CHK(sck, 1'b0)
    bus(1'b0, BUF_OFS, 8'h00);
    `CHK(q, 8'hA5)
    bus(1'b1, IRQ_MASK_OFS, 8'h00);
    settle;
    `CHK(irq, 1'b0)
    bus(1'b1, IRQ_MASK_OFS, 8'h01);
    settle;
    `CHK(irq, 1'b1)
    bus(1'b1, IRQ_STAT_OFS, 8'h01);
    settle;
    `CHK(irq, 1'b0)
    bus(1'b0, BUF_OFS, 8'h00);
    `CHK(q, 8'hA5)
    $display("test transfer done");
  endtask
  task t_slave;
    load <= 1'b1;
    bus(1'b1, CON1_OFS, 8'h20);
    load <= 1'b0;
    bus(1'b1, BUF_OFS, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      sck_pin <= 1'b1;
      repeat (8) @(posedge mclk_in);
      sck_pin <= 1'b0;
      repeat (8) @(posedge mclk_in);
    end
    `CHK(sck, 1'b0)
    `CHK(rx, 8'h5A)
    `CHK(irq, 1'b1)
    bus(1'b0, BUF_OFS, 8'h00);
    `CHK(q, 8'hA5)
    bus(1'b1, IRQ_STAT_OFS, 8'h01);
    bus(1'b1, CON1_OFS, 8'h00);
    settle;
    `CHK(irq, 1'b0)
    $display("test slave done");
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_reset;
    t_con1;
    t_stat;
    t_xfer;
    t_slave;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge mclk_in);
    fails++;
    give_verdict;
  end
endmodule // testbench
